// *** core/dcd_pkg.sv ***
/*
 * Constants, field positions and types shared by the converter clock and
 * delay-controller register bank and its serial configuration port.
 * Assumes a single 100 MHz system clock and a serial clock far slower.
 */
// Contract
// R1 - Clock receiver enable resets to zero.
// R2 - Software enables receiver after clock stable.
// R3 - Positive pin sign bit selects trim polarity.
// R4 - Bits 4:1 hold positive pin level trim.
// R5 - Bit 0 selects negative pin trim polarity.
// R6 - Bit 7 stops the delay controller clock.
// R7 - Controller compares measured slope with slope bit.
// R8 - Mode field selects search, track or both.
// R9 - Rising snapshot bit captures locked delay, phase.
// R10 - Gain field sets tracking speed.
// R11 - Enable bit selects manual or automatic mode.
// R12 - Software enables boost and duty correction first.
// R13 - Bias bit 7 powers converter down.
// R14 - Roll-off field selects current-mirror filtering.
// R15 - Decoder field selects output coding.
// R16 - Software never writes code 11 to fields.
// R17 - Delay readback is nine bits, max 431.
// R18 - Captured readback holds until next snapshot. In manual mode, writes to 0x39 and 0x3A also change it.
package dcd_pkg;

    // =========================================================
    // Register map
    localparam int ADDR_W = 13;
    localparam int DLY_W = 9;
    localparam int PHZ_W = 5;
    localparam logic [12:0] ADDR_CLK_RX = 13'h0032;
    localparam logic [12:0] ADDR_DLY_CTL = 13'h0033;
    localparam logic [12:0] ADDR_BIAS = 13'h0036;
    localparam logic [12:0] ADDR_DEC = 13'h0038;
    localparam logic [12:0] ADDR_DLY3 = 13'h0039;
    localparam logic [12:0] ADDR_DLY4 = 13'h003A;

    // =========================================================
    // Field positions
    localparam int CRX_ON_BIT = 7;
    localparam int CRX_POS_PIN_BIAS_SIGN_BIT = 5;
    localparam int CRX_PLVL_LSB = 1;
    localparam int CRX_NEG_PIN_BIAS_SIGN_BIT = 0;
    localparam int DC_CLKOFF_BIT = 7;
    localparam int DC_SLOPE_BIT = 6;
    localparam int DC_MODE_LSB = 4;
    localparam int DC_SNAP_BIT = 3;
    localparam int DC_GAIN_LSB = 1;
    localparam int DC_EN_BIT = 0;
    localparam int BIAS_PD_BIT = 7;
    localparam int D3_DLY_BIT = 7;
    localparam int D3_DIR_LSB = 5;

    // =========================================================
    // Reset values and masks
    localparam logic [7:0] CLK_RX_RST = 8'h00;
    localparam logic [7:0] DLY_CTL_RST = 8'h00;
    localparam logic [7:0] BIAS_RST = 8'h00;
    localparam logic [7:0] DEC_RST = 8'h00;
    localparam logic [7:0] BIAS_MASK = 8'h83;
    localparam logic [7:0] DEC_MASK = 8'h03;
    localparam logic [8:0] DLY_RST = 9'h0D8;
    localparam logic [8:0] DLY_MAX = 9'h1AF;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // =========================================================
    // Serial port framing
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0F;
    localparam logic [4:0] SPI_DATA_LAST = 5'h07;
    localparam int SPI_RD_BIT = 15;

    typedef enum logic [4:0] {
        SPI_IDLE = 5'h01,
        SPI_INSTR = 5'h02,
        SPI_LOAD = 5'h04,
        SPI_DATA = 5'h08,
        SPI_DONE = 5'h10
    } dcd_spi_state_type;

    function automatic logic [8:0] dcd_sat(input logic [8:0] v);
        return (v > DLY_MAX) ? DLY_MAX : v;
    endfunction

endpackage

// *** core/dcd_reg_if.sv ***
/*
 * Internal register access path between the serial port and the bank.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface dcd_reg_if;
    logic wr_stb;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr_stb, output addr, output wdata, input rdata);
    modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** core/dcd_spi_slave.sv ***
/*
 * Three-wire serial configuration port: 16-bit instruction, one data byte.
 * Assumes the serial clock runs at most one eighth of the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
module dcd_spi_slave
    import dcd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // Serial pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_n,
    // Register side
    dcd_reg_if.slave bus
);
    logic [2:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] sdi_sync_reg;
    dcd_spi_state_type state_reg;
    logic [4:0] cnt_reg;
    logic [15:0] shift_reg;
    logic rd_reg;
    logic [12:0] addr_reg;
    logic [7:0] sdo_reg;
    logic oe_n_reg;
    logic wr_stb_reg;

    wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    wire cs_idle = cs_sync_reg[1];
    wire [15:0] shift_next = {shift_reg[14:0], sdi_sync_reg[1]};

    assign bus.wr_stb = wr_stb_reg;
    assign bus.addr = addr_reg;
    assign bus.wdata = shift_reg[7:0];
    assign spi_sdio_out = sdo_reg[7];
    assign spi_sdio_oe_n = oe_n_reg;

    // =========================================================
    // Pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg <= 2'h3;
            sdi_sync_reg <= 2'h0;
        end else if (ce) begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
            cs_sync_reg <= {cs_sync_reg[0], spi_cs_n};
            sdi_sync_reg <= {sdi_sync_reg[0], spi_sdio_in};
        end
    end

    // =========================================================
    // Framing
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= SPI_IDLE;
            cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            rd_reg <= 1'b0;
            addr_reg <= 13'h0000;
            sdo_reg <= 8'h00;
            oe_n_reg <= 1'b1;
            wr_stb_reg <= 1'b0;
        end else if (ce) begin
            wr_stb_reg <= 1'b0;
            case (state_reg)
                SPI_IDLE: if (!cs_idle) begin
                    state_reg <= SPI_INSTR;
                    cnt_reg <= 5'h00;
                end
                SPI_INSTR: if (cs_idle) begin
                    state_reg <= SPI_IDLE;
                end else if (sclk_rise) begin
                    shift_reg <= shift_next;
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == SPI_INSTR_LAST) begin
                        rd_reg <= shift_next[SPI_RD_BIT];
                        addr_reg <= shift_next[ADDR_W-1:0];
                        state_reg <= SPI_LOAD;
                    end
                end
                SPI_LOAD: begin
                    // Read data is latched whole so a later write cannot tear it.
                    sdo_reg <= bus.rdata;
                    oe_n_reg <= ~rd_reg;
                    cnt_reg <= 5'h00;
                    state_reg <= SPI_DATA;
                end
                SPI_DATA: if (cs_idle) begin
                    oe_n_reg <= 1'b1;
                    state_reg <= SPI_IDLE;
                end else if (sclk_rise) begin
                    shift_reg <= shift_next;
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == SPI_DATA_LAST) begin
                        wr_stb_reg <= ~rd_reg;
                        state_reg <= SPI_DONE;
                    end
                end else if (sclk_fall && cnt_reg != 5'h00) begin
                    sdo_reg <= {sdo_reg[6:0], 1'b0};
                end
                SPI_DONE: if (cs_idle) begin
                    oe_n_reg <= 1'b1;
                    state_reg <= SPI_IDLE;
                end
                default: state_reg <= SPI_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** core/dcd_regs.sv ***
/*
 * Converter clock receiver, delay-tracking controller, bias and decoder
 * control registers, reached over the serial configuration port.
 * Assumes the delay controller's locked values are on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
module dcd_regs
    import dcd_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // Serial configuration port
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_n,
    // Locked values from the delay controller
    input wire logic [DLY_W-1:0] locked_delay_in,
    input wire logic [PHZ_W-1:0] locked_phase_in,
    // Clock receiver controls
    output logic clock_receiver_on,
    output logic pos_pin_bias_sign,
    output logic [3:0] pos_pin_bias_level,
    output logic neg_pin_bias_sign,
    // Delay controller controls
    output logic delay_ctrl_clock_off,
    output logic delay_slope_positive,
    output logic [1:0] delay_ctrl_mode,
    output logic [1:0] delay_ctrl_gain,
    output logic delay_ctrl_on,
    output logic [DLY_W-1:0] locked_delay_value,
    output logic [PHZ_W-1:0] locked_phase_value,
    output logic [1:0] search_direction,
    // Converter controls
    output logic converter_power_down,
    output logic [1:0] mirror_rolloff_select,
    output logic [1:0] decoder_mode
);
    dcd_reg_if rif ();

    logic [7:0] clk_rx_reg;
    logic [7:0] dly_ctl_reg;
    logic [7:0] bias_reg;
    logic [7:0] dec_reg;
    logic [DLY_W-1:0] dly_reg;
    logic [DLY_W-1:0] dly_next;
    logic [PHZ_W-1:0] phz_reg;
    logic [PHZ_W-1:0] phz_next;
    logic [1:0] dir_reg;

    dcd_spi_slave u_spi (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdio_in(spi_sdio_in),
        .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe_n(spi_sdio_oe_n),
        .bus(rif.slave)
    );

    // =========================================================
    // Address decode
    wire wr = ce & rif.wr_stb;
    wire wr_crx = wr & (rif.addr == ADDR_CLK_RX);
    wire wr_dlc = wr & (rif.addr == ADDR_DLY_CTL);
    wire wr_bias = wr & (rif.addr == ADDR_BIAS);
    wire wr_dec = wr & (rif.addr == ADDR_DEC);
    wire wr_d3 = wr & (rif.addr == ADDR_DLY3);
    wire wr_d4 = wr & (rif.addr == ADDR_DLY4);
    wire [7:0] wd = rif.wdata;

    // R9 snapshot edge detect
    wire snap_evt = wr_dlc & wd[DC_SNAP_BIT] & ~dly_ctl_reg[DC_SNAP_BIT];
    // R11 manual write access
    wire manual = ~dly_ctl_reg[DC_EN_BIT];
    wire [DLY_W-1:0] dly_wr = wr_d3 ? {dly_reg[8:1], wd[D3_DLY_BIT]} : {wd, dly_reg[0]};

    // R18 hold captured values
    assign dly_next = snap_evt ? dcd_sat(locked_delay_in)
                    : (manual & (wr_d3 | wr_d4)) ? dcd_sat(dly_wr) : dly_reg;
    assign phz_next = snap_evt ? locked_phase_in
                    : (manual & wr_d3) ? wd[PHZ_W-1:0] : phz_reg;

    // =========================================================
    // Readback
    wire [7:0] rd_d3 = {dly_reg[0], dir_reg, phz_reg};
    assign rif.rdata = (rif.addr == ADDR_CLK_RX) ? clk_rx_reg
                     : (rif.addr == ADDR_DLY_CTL) ? dly_ctl_reg
                     : (rif.addr == ADDR_BIAS) ? (bias_reg & BIAS_MASK)
                     : (rif.addr == ADDR_DEC) ? (dec_reg & DEC_MASK)
                     : (rif.addr == ADDR_DLY3) ? rd_d3
                     : (rif.addr == ADDR_DLY4) ? dly_reg[8:1] : RD_UNMAPPED;

    // =========================================================
    // Registers
    // R1 receiver held off at reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clk_rx_reg <= CLK_RX_RST;
            dly_ctl_reg <= DLY_CTL_RST;
            bias_reg <= BIAS_RST;
            dec_reg <= DEC_RST;
        end else begin
            if (wr_crx) begin
                clk_rx_reg <= wd;
            end
            if (wr_dlc) begin
                dly_ctl_reg <= wd;
            end
            if (wr_bias) begin
                bias_reg <= wd & BIAS_MASK;
            end
            if (wr_dec) begin
                dec_reg <= wd & DEC_MASK;
            end
        end
    end

    // R9 capture locked values
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dly_reg <= DLY_RST;
            phz_reg <= 5'h00;
            dir_reg <= 2'h0;
        end else if (ce) begin
            dly_reg <= dly_next;
            phz_reg <= phz_next;
            if (wr_d3) begin
                dir_reg <= wd[D3_DIR_LSB +: 2];
            end
        end
    end

    // =========================================================
    // Field outputs
    // R3 R4 R5 pin trim fields
    assign clock_receiver_on = clk_rx_reg[CRX_ON_BIT];
    assign pos_pin_bias_sign = clk_rx_reg[CRX_POS_PIN_BIAS_SIGN_BIT];
    assign pos_pin_bias_level = clk_rx_reg[CRX_PLVL_LSB +: 4];
    assign neg_pin_bias_sign = clk_rx_reg[CRX_NEG_PIN_BIAS_SIGN_BIT];
    // R6 controller clock gate
    assign delay_ctrl_clock_off = dly_ctl_reg[DC_CLKOFF_BIT];
    // R7 slope for comparison
    assign delay_slope_positive = dly_ctl_reg[DC_SLOPE_BIT];
    // R8 R10 mode and gain
    assign delay_ctrl_mode = dly_ctl_reg[DC_MODE_LSB +: 2];
    assign delay_ctrl_gain = dly_ctl_reg[DC_GAIN_LSB +: 2];
    // R11 manual or automatic
    assign delay_ctrl_on = dly_ctl_reg[DC_EN_BIT];
    assign locked_delay_value = dly_reg;
    assign locked_phase_value = phz_reg;
    assign search_direction = dir_reg;
    // R13 R14 R15 converter fields
    assign converter_power_down = bias_reg[BIAS_PD_BIT];
    assign mirror_rolloff_select = bias_reg[1:0];
    assign decoder_mode = dec_reg[1:0];

    // =========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_rx_reset;
        $fell(srst) |-> !clock_receiver_on;
    endproperty
    a_rx_reset: assert property (p_rx_reset) else $error("receiver on after reset"); // R1

    property p_snap;
        snap_evt |=> locked_phase_value == $past(locked_phase_in);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot phase not captured"); // R9

    property p_hold;
        (!snap_evt && !manual && ce) |=> $stable(locked_delay_value) && $stable(locked_phase_value);
    endproperty
    a_hold: assert property (p_hold) else $error("readback changed without snapshot"); // R18

    property p_dly_max;
        locked_delay_value <= DLY_MAX;
    endproperty
    a_dly_max: assert property (p_dly_max) else $error("delay above limit"); // R17

    property p_clk_off;
        wr_dlc |=> delay_ctrl_clock_off == $past(wd[DC_CLKOFF_BIT]);
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock gate not written"); // R6

    property p_pd;
        (wr_bias && wd[BIAS_PD_BIT]) |=> converter_power_down [*2] or wr_bias;
    endproperty
    a_pd: assert property (p_pd) else $error("power down not held"); // R13

    property p_mirror_rolloff_select;
        wr_bias |=> mirror_rolloff_select == $past(wd[1:0]) && rif.rdata[6:2] == 5'h00
            || rif.addr != ADDR_BIAS;
    endproperty
    a_mirror_rolloff_select: assert property (p_mirror_rolloff_select) else $error("roll-off field wrong"); // R14

    property p_dec;
        wr_dec ##1 !wr_dec |-> decoder_mode == $past(wd[1:0]);
    endproperty
    a_dec: assert property (p_dec) else $error("decoder mode wrong"); // R15

    property p_rx_wr;
        wr_crx |=> clock_receiver_on == $past(wd[CRX_ON_BIT]);
    endproperty
    a_rx_wr: assert property (p_rx_wr) else $error("receiver enable not written"); // R1

    property p_snap_dly;
        snap_evt |=> locked_delay_value == (($past(locked_delay_in) > DLY_MAX) ? DLY_MAX
            : $past(locked_delay_in));
    endproperty
    a_snap_dly: assert property (p_snap_dly) else $error("snapshot delay not captured"); // R9

    property p_auto_lock;
        (wr_d4 && !manual) |=> $stable(locked_delay_value);
    endproperty
    a_auto_lock: assert property (p_auto_lock) else $error("delay written in auto mode"); // R11
endmodule
`default_nettype wire

// *** sim/tb_dcd_regs.sv ***
/*
 * Self-checking bench for the converter clock and delay-controller register bank.
 * Assumes the package, interface and design modules under core/ are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_dcd_regs;
    import dcd_pkg::*;

    typedef struct packed {logic [12:0] a; logic [7:0] w; logic [7:0] r;} dcd_row_type;

    // =========================================================
    // Signals
    logic sys_clk, srst, ce, spi_sclk, spi_cs_n, spi_sdio_in, tb_sdio;
    logic spi_sdio_out, spi_sdio_oe_n, clock_receiver_on, pos_pin_bias_sign, neg_pin_bias_sign;
    logic delay_ctrl_clock_off, delay_slope_positive, delay_ctrl_on, converter_power_down;
    logic [3:0] pos_pin_bias_level;
    logic [1:0] delay_ctrl_mode, delay_ctrl_gain, search_direction, mirror_rolloff_select;
    logic [1:0] decoder_mode;
    logic [DLY_W-1:0] locked_delay_in, locked_delay_value;
    logic [PHZ_W-1:0] locked_phase_in, locked_phase_value;
    logic [7:0] rd;
    int mismatches, checks_done;
    dcd_row_type rows [16] = '{
        '{13'h0032, 8'hBF, 8'hBF}, '{13'h0032, 8'h1E, 8'h1E}, '{13'h0033, 8'h80, 8'h80},
        '{13'h0033, 8'h42, 8'h42}, '{13'h0033, 8'h14, 8'h14}, '{13'h0033, 8'h20, 8'h20},
        '{13'h0033, 8'h01, 8'h01}, '{13'h0033, 8'h00, 8'h00}, '{13'h0036, 8'hFD, 8'h81},
        '{13'h0036, 8'h02, 8'h02}, '{13'h0036, 8'h03, 8'h03}, '{13'h0036, 8'h00, 8'h00},
        '{13'h0038, 8'hFD, 8'h01}, '{13'h0038, 8'h02, 8'h02}, '{13'h0038, 8'h00, 8'h00},
        '{13'h0037, 8'h55, 8'h00}};

    // The data pin is shared: while the bank drives it, the bench's value is overridden.
    assign spi_sdio_in = (spi_sdio_oe_n === 1'b0) ? spi_sdio_out : tb_sdio;

    dcd_regs dcd_regs_inst (
        .sys_clk(sys_clk), .srst(srst), .ce(ce), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe_n(spi_sdio_oe_n),
        .locked_delay_in(locked_delay_in), .locked_phase_in(locked_phase_in),
        .clock_receiver_on(clock_receiver_on), .pos_pin_bias_sign(pos_pin_bias_sign),
        .pos_pin_bias_level(pos_pin_bias_level), .neg_pin_bias_sign(neg_pin_bias_sign),
        .delay_ctrl_clock_off(delay_ctrl_clock_off), .delay_slope_positive(delay_slope_positive),
        .delay_ctrl_mode(delay_ctrl_mode), .delay_ctrl_gain(delay_ctrl_gain),
        .delay_ctrl_on(delay_ctrl_on), .locked_delay_value(locked_delay_value),
        .locked_phase_value(locked_phase_value), .search_direction(search_direction),
        .converter_power_down(converter_power_down),
        .mirror_rolloff_select(mirror_rolloff_select), .decoder_mode(decoder_mode)
    );

    // =========================================================
    // Checking and reporting
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Output pins of one register, laid out like its byte; the snapshot bit has no pin.
    function automatic logic [7:0] pins(input logic [12:0] a);
        case (a)
            13'h0032: return {clock_receiver_on, 1'b0, pos_pin_bias_sign, pos_pin_bias_level,
                neg_pin_bias_sign};
            13'h0033: return {delay_ctrl_clock_off, delay_slope_positive, delay_ctrl_mode, 1'b0,
                delay_ctrl_gain, delay_ctrl_on};
            13'h0036: return {converter_power_down, 5'h00, mirror_rolloff_select};
            13'h0038: return {6'h00, decoder_mode};
            default: return 8'h00;
        endcase
    endfunction

    // =========================================================
    // Serial frame: sclk at one sixteenth of sys_clk, well under the one-eighth limit.
    task automatic spi(input logic rdn, input logic [12:0] a, input logic [7:0] w,
            output logic [7:0] r);
        logic [23:0] f;
        f = {rdn, 2'b00, a, w};
        r = 8'h00;
        @(negedge sys_clk) spi_cs_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        for (int i = 23; i >= 0; i--) begin
            spi_sclk = 1'b0;
            tb_sdio = f[i];
            repeat (8) @(negedge sys_clk);
            r[i % 8] = spi_sdio_out;
            if (rdn && i == 7) chk("oe_n", 9'h000, {8'h00, spi_sdio_oe_n});
            spi_sclk = 1'b1;
            repeat (8) @(negedge sys_clk);
        end
        spi_sclk = 1'b0;
        repeat (2) @(negedge sys_clk);
        spi_cs_n = 1'b1;
        tb_sdio = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] w);
        logic [7:0] d;
        spi(1'b0, a, w, d);
    endtask

    task automatic rdchk(input string n, input logic [12:0] a, input logic [7:0] e);
        logic [7:0] d;
        spi(1'b1, a, 8'h00, d);
        chk(n, {1'b0, e}, {1'b0, d});
    endtask

    // =========================================================
    // Stimulus
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        tb_sdio = 1'b0;
        locked_delay_in = 9'h000;
        locked_phase_in = 5'h00;
        mismatches = 0;
        checks_done = 0;
        repeat (20) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("rx_on rst", 9'h000, {8'h00, clock_receiver_on});
        chk("dly rst", DLY_RST, locked_delay_value);
        foreach (rows[k]) rdchk("rst rd", rows[k].a, 8'h00);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w);
            rdchk("row rd", rows[k].a, rows[k].r);
            chk("row pins", {1'b0, rows[k].r}, {1'b0, pins(rows[k].a)});
        end
        locked_delay_in = 9'h1F0;
        locked_phase_in = 5'h0E;
        wr(ADDR_DLY_CTL, 8'h01);
        wr(ADDR_DLY_CTL, 8'h09);
        chk("snap dly", DLY_MAX, locked_delay_value);
        chk("snap phz", 9'h00E, {4'h0, locked_phase_value});
        locked_delay_in = 9'h055;
        locked_phase_in = 5'h03;
        wr(ADDR_DLY_CTL, 8'h09);
        wr(ADDR_DLY_CTL, 8'h01);
        wr(ADDR_DLY4, 8'h00);
        chk("hold dly", DLY_MAX, locked_delay_value);
        chk("hold phz", 9'h00E, {4'h0, locked_phase_value});
        rdchk("rd dly hi", ADDR_DLY4, 8'hD7);
        rdchk("rd dly lo", ADDR_DLY3, 8'h8E);
        wr(ADDR_DLY_CTL, 8'h09);
        chk("resnap dly", 9'h055, locked_delay_value);
        chk("resnap phz", 9'h003, {4'h0, locked_phase_value});
        wr(ADDR_DLY_CTL, 8'h00);
        wr(ADDR_DLY4, 8'h10);
        wr(ADDR_DLY3, 8'hCE);
        chk("man dly", 9'h021, locked_delay_value);
        chk("man dir", 9'h002, {7'h00, search_direction});
        chk("man phz", 9'h00E, {4'h0, locked_phase_value});
        wr(ADDR_DLY4, 8'hFF);
        chk("sat dly", DLY_MAX, locked_delay_value);
        wr(ADDR_CLK_RX, 8'h80);
        chk("rx_on set", 9'h001, {8'h00, clock_receiver_on});
        ce = 1'b0;
        wr(ADDR_CLK_RX, 8'h00);
        ce = 1'b1;
        chk("ce freeze", 9'h001, {8'h00, clock_receiver_on});
        @(negedge sys_clk) srst = 1'b1;
        repeat (4) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("rx_on rerst", 9'h000, {8'h00, clock_receiver_on});
        chk("dly rerst", DLY_RST, locked_delay_value);
        rdchk("rerst rd", ADDR_CLK_RX, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
